// >>> rtl/mwd_pkg.sv
// Purpose: shared constants and carriers for the core watchdog
// Assumes: special function register port of the core, 8-bit data
// Notes:   addresses are the core's direct addresses
package mwd_pkg;

    localparam int          SFR_AW        = 8;
    localparam int          CNT_W         = 15;
    localparam int          RELOAD_W      = 7;
    localparam int          LOW_W         = CNT_W - RELOAD_W;

    // register map
    localparam logic [7:0]  ADDR_RELOAD   = 8'h86;
    localparam logic [7:0]  ADDR_PWRCTL   = 8'h87;
    localparam logic [7:0]  ADDR_IEN_A    = 8'hA8;
    localparam logic [7:0]  ADDR_IEN_B    = 8'hB8;

    // field positions
    localparam int          BIT_PRESEL    = 7;
    localparam int          BIT_ARM       = 6;
    localparam int          BIT_CONFIRM   = 6;
    localparam int          BIT_TESTMODE  = 6;

    // reset values
    localparam logic [7:0]  RST_RELOAD    = 8'h00;
    localparam logic [7:0]  RST_IEN       = 8'h00;
    localparam logic [7:0]  RST_PWRCTL    = 8'h08;
    // power control bits with no function here read as fixed
    localparam logic [7:0]  PWRCTL_FIXED  = 8'h08;

    // timeout window
    localparam logic [14:0] CNT_RST_ON    = 15'h7FFC;
    localparam logic [14:0] CNT_TOP       = 15'h7FFF;

    // prescale: core clocks per counter step
    localparam int          DIV_FAST      = 24;
    localparam int          DIV_SLOW      = 384;
    localparam int          PRE_W         = 9;

    typedef struct packed {
        logic                  wr;     // write strobe
        logic [SFR_AW-1:0]     addr;   // direct address
        logic [7:0]            wdata;  // write data
        logic                  instr_done; // one instruction retired
    } mwd_sfr_req_t;

endpackage : mwd_pkg

// >>> rtl/mwd_prescaler.sv
// Purpose: divide the core clock into watchdog count ticks
// Assumes: clr restarts the division from zero
// Notes:   a tick is a one-cycle pulse
module mwd_prescaler #(
    parameter int FAST_DIV = mwd_pkg::DIV_FAST,
    parameter int SLOW_DIV = mwd_pkg::DIV_SLOW
) (
    input  wire logic clock,    // core clock
    input  wire logic sys_rst,  // async reset, high
    input  wire logic run,      // watchdog started
    input  wire logic clr,      // restart division
    input  wire logic slow,     // long prescale
    input  wire logic bypass,   // test mode, tick every cycle
    output logic      tick      // count step pulse
);
    if (FAST_DIV < 1 || SLOW_DIV < FAST_DIV || SLOW_DIV > (1 << mwd_pkg::PRE_W)) begin : g_bad_div
        $error("mwd_prescaler: bad divide values");
    end

    typedef struct packed {
        logic [mwd_pkg::PRE_W-1:0] cnt;
        logic                      tick;
    } mwd_pre_state_t;

    mwd_pre_state_t st;
    mwd_pre_state_t next_st;
    logic [mwd_pkg::PRE_W-1:0] last;

    always_comb begin
        next_st = st;
        last = slow ? mwd_pkg::PRE_W'(SLOW_DIV - 1) : mwd_pkg::PRE_W'(FAST_DIV - 1);
        next_st.tick = 1'b0;
        if (!run || clr) begin
            next_st.cnt = '0;
        end else if (bypass) begin
            next_st.cnt  = '0;
            next_st.tick = 1'b1;
        end else if (st.cnt >= last) begin
            next_st.cnt  = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + mwd_pkg::PRE_W'(1);
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule : mwd_prescaler

// >>> rtl/mcu_watchdog_timer.sv
// Purpose: core watchdog with reload, arm/confirm refresh and reset flag
// Assumes: core presents one write per cycle and pulses instr_done per instruction
// Notes:   started only by the refresh sequence; halted only by sys_rst

// Functional notes
// - reload bit 7 set: counter steps once every 384 core clocks.
// - reload bit 7 clear: counter steps once every 24 core clocks.
// - 15-bit counter with reload register and selectable prescaler.
// - test mode bypasses all prescaling; counter steps every clock.
// - idle after reset; software starts it with reload then refresh sequence.
// - once running, nothing but hardware reset stops it.
// - internal reset output asserts when counter reaches 7FFC.
// - watchdog reset sets sticky status flag, cleared only by hardware reset.
// - internal reset does not reset the watchdog; it keeps counting.
// - wrap 7FFF to 0000 releases internal reset, flag stays set.
// - confirm set right after arm refreshes; confirm clears at once.
// - start or refresh loads reload bits 6:0 into counter top bits.
// - test mode is power control bit 6, removing the prescaler.
module mcu_watchdog_timer #(
    parameter int FAST_DIV = mwd_pkg::DIV_FAST,
    parameter int SLOW_DIV = mwd_pkg::DIV_SLOW
) (
    input  wire logic                 clock,       // core clock, 40 MHz
    input  wire logic                 sys_rst,     // async hardware reset, high
    input  wire mwd_pkg::mwd_sfr_req_t sfr_req,    // register write / instruction
    input  wire logic                 sfr_rd,      // read strobe
    input  wire logic [7:0]           sfr_raddr,   // read address
    output logic [7:0]                sfr_rdata,   // registered read data
    output logic                      sfr_rvalid,  // read data valid pulse
    output logic                      wd_reset,    // internal reset to core
    output logic                      wd_flag,     // sticky watchdog reset status
    output logic                      wd_running,  // watchdog started
    output logic                      test_mode    // watchdog test mode
);
    typedef struct packed {
        logic [7:0]                 reload;
        logic [7:0]                 ien_a;
        logic [7:0]                 ien_b;
        logic [7:0]                 pwrctl;
        logic                       arm_seen;  // arming instruction has retired
        logic [mwd_pkg::CNT_W-1:0]  cnt;
        logic                       run;
        logic                       rst_out;
        logic                       flag;
        logic [7:0]                 rdata;
        logic                       rvalid;
    } mwd_state_t;

    mwd_state_t st;
    mwd_state_t next_st;
    logic       tick;
    logic       refresh;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
        hit = sfr_req.wr && (a == ref_a);
    endfunction : hit

    mwd_prescaler #(
        .FAST_DIV (FAST_DIV),
        .SLOW_DIV (SLOW_DIV)
    ) u_pre (
        .clock   (clock),
        .sys_rst (sys_rst),
        .run     (st.run),
        .clr     (refresh),
        .slow    (st.reload[mwd_pkg::BIT_PRESEL]),
        .bypass  (st.pwrctl[mwd_pkg::BIT_TESTMODE]),
        .tick    (tick)
    );

    // confirm counts only while arm is still standing from the previous instruction
    always_comb begin
        refresh = hit(sfr_req.addr, mwd_pkg::ADDR_IEN_B)
                  && sfr_req.wdata[mwd_pkg::BIT_CONFIRM]
                  && st.ien_a[mwd_pkg::BIT_ARM];
    end

    always_comb begin
        next_st        = st;
        next_st.rvalid = 1'b0;

        if (hit(sfr_req.addr, mwd_pkg::ADDR_RELOAD)) begin
            next_st.reload = sfr_req.wdata;
        end
        if (hit(sfr_req.addr, mwd_pkg::ADDR_PWRCTL)) begin
            next_st.pwrctl = mwd_pkg::PWRCTL_FIXED;
            next_st.pwrctl[mwd_pkg::BIT_TESTMODE] = sfr_req.wdata[mwd_pkg::BIT_TESTMODE];
        end

        // arm bit: cleared once the instruction after the arming one retires,
        // so a nop between arm and confirm loses the refresh
        if (hit(sfr_req.addr, mwd_pkg::ADDR_IEN_A)) begin
            next_st.ien_a    = sfr_req.wdata;
            next_st.arm_seen = sfr_req.instr_done;
        end else if (st.ien_a[mwd_pkg::BIT_ARM] && sfr_req.instr_done) begin
            if (st.arm_seen) begin
                next_st.ien_a[mwd_pkg::BIT_ARM] = 1'b0;
                next_st.arm_seen = 1'b0;
            end else begin
                next_st.arm_seen = 1'b1;
            end
        end

        // confirm bit never stays set
        if (hit(sfr_req.addr, mwd_pkg::ADDR_IEN_B)) begin
            next_st.ien_b = sfr_req.wdata;
            next_st.ien_b[mwd_pkg::BIT_CONFIRM] = 1'b0;
        end

        if (refresh) begin
            next_st.run = 1'b1;
            next_st.ien_a[mwd_pkg::BIT_ARM] = 1'b0;
            next_st.arm_seen = 1'b0;
            next_st.cnt = {st.reload[mwd_pkg::RELOAD_W-1:0],
                           {mwd_pkg::LOW_W{1'b0}}};
        end else if (st.run && tick) begin
            next_st.cnt = st.cnt + mwd_pkg::CNT_W'(1);
        end

        // reset window spans 7FFC up to the wrap
        if (st.run && next_st.cnt == mwd_pkg::CNT_RST_ON && !refresh) begin
            next_st.rst_out = 1'b1;
            next_st.flag    = 1'b1;
        end
        if (st.run && tick && !refresh && st.cnt == mwd_pkg::CNT_TOP) begin
            next_st.rst_out = 1'b0;
        end
        if (refresh) begin
            next_st.rst_out = 1'b0;
        end

        if (sfr_rd) begin
            next_st.rvalid = 1'b1;
            case (sfr_raddr)
                mwd_pkg::ADDR_RELOAD: next_st.rdata = st.reload;
                mwd_pkg::ADDR_PWRCTL: next_st.rdata = st.pwrctl;
                mwd_pkg::ADDR_IEN_A:  next_st.rdata = st.ien_a;
                mwd_pkg::ADDR_IEN_B:  next_st.rdata = st.ien_b;
                default:              next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st        <= '0;
            st.reload <= mwd_pkg::RST_RELOAD;
            st.ien_a  <= mwd_pkg::RST_IEN;
            st.ien_b  <= mwd_pkg::RST_IEN;
            st.pwrctl <= mwd_pkg::RST_PWRCTL;
        end else begin
            st <= next_st;
        end
    end

    assign sfr_rdata  = st.rdata;
    assign sfr_rvalid = st.rvalid;
    assign wd_reset   = st.rst_out;
    assign wd_flag    = st.flag;
    assign wd_running = st.run;
    assign test_mode  = st.pwrctl[mwd_pkg::BIT_TESTMODE];
endmodule : mcu_watchdog_timer

// >>> sim/mwd_chk_checker.sv
// Purpose: port assertions for the core watchdog
// Assumes: no refresh while core reset is high
// Notes:   bound from the bench top
module mwd_chk #(
    parameter int FAST_DIV = 24,
    parameter int SLOW_DIV = 384
) (
    input wire logic                  clock,      // clock
    input wire logic                  sys_rst,    // reset
    input wire mwd_pkg::mwd_sfr_req_t sfr_req,    // writes
    input wire logic                  sfr_rd,     // read
    input wire logic [7:0]            sfr_raddr,  // address
    input wire logic [7:0]            sfr_rdata,  // data
    input wire logic                  sfr_rvalid, // valid
    input wire logic                  wd_reset,   // core reset
    input wire logic                  wd_flag,    // status
    input wire logic                  wd_running, // started
    input wire logic                  test_mode   // test mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    logic slow;
    logic conf_q;
    int   hi_cnt;
    sequence arm_s;
        sfr_req.wr && sfr_req.instr_done && sfr_req.addr == 8'hA8 && sfr_req.wdata[6];
    endsequence
    sequence conf_s;
        sfr_req.wr && sfr_req.addr == 8'hB8 && sfr_req.wdata[6];
    endsequence
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            slow   <= 1'b0;
            conf_q <= 1'b0;
            hi_cnt <= 0;
        end else begin
            if (sfr_req.wr && sfr_req.addr == 8'h86) begin
                slow <= sfr_req.wdata[7];
            end
            conf_q <= sfr_req.wr && sfr_req.addr == 8'hB8 && sfr_req.wdata[6];
            hi_cnt <= wd_reset ? hi_cnt + 1 : 0;
        end
    end
    read_answer_a: assert property (sfr_rd |=> sfr_rvalid) else $error("read not answered");
    refresh_start_a: assert property (arm_s ##1 conf_s |=> wd_running)
        else $error("refresh did not start");
    start_cause_a: assert property ($rose(wd_running) |-> conf_q)
        else $error("start without refresh");
    run_hold_a: assert property (wd_running |=> wd_running) else $error("halted");
    flag_hold_a: assert property (wd_flag |=> wd_flag) else $error("flag lost");
    flag_with_reset_a: assert property (wd_reset |-> wd_flag)
        else $error("reset without flag");
    // a refresh inside the window ends it early, so skip that case
    reset_span_a: assert property ($fell(wd_reset) && !conf_q |->
        hi_cnt == 4 * (test_mode ? 1 : slow ? SLOW_DIV : FAST_DIV)) else $error("reset span");
    confirm_reads0_a: assert property (sfr_rd && sfr_raddr == 8'hB8 |=> !sfr_rdata[6])
        else $error("confirm bit stuck");
endmodule : mwd_chk

// >>> sim/mwd_cpu.sv
// Purpose: core side issuing instructions and register reads
// Assumes: one instruction per clock
// Notes:   released address and data lines show the inverse of their last value; strobes drop low
module mwd_cpu (
    input  wire logic             clock,      // clock
    input  wire logic [7:0]       sfr_rdata,  // data
    input  wire logic             sfr_rvalid, // valid
    output mwd_pkg::mwd_sfr_req_t sfr_req,    // writes
    output logic                  sfr_rd,     // read
    output logic [7:0]            sfr_raddr   // address
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sfr_req = '0;
        sfr_rd = 1'b0;
        sfr_raddr = 8'h00;
    end
    task automatic instr(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_req <= '{w, a, d, 1'b1};
    endtask : instr
    task automatic idle();
        @(posedge clock);
        sfr_req <= '{1'b0, ~sfr_req.addr, ~sfr_req.wdata, 1'b0};
        sfr_rd <= 1'b0;
        sfr_raddr <= ~sfr_raddr;
    endtask : idle
    task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clock);
        sfr_rd <= 1'b1;
        sfr_raddr <= a;
        idle();
        @(posedge clock);
        d = sfr_rdata;
        v = sfr_rvalid;
    endtask : read
endmodule : mwd_cpu

// >>> sim/testbench.sv
// Purpose: self-checking bench for the core watchdog
// Assumes: slow prescale shortened to 48 to keep the run brief
// Notes:   expected timeouts follow from reload and divider
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int         FD = 24;
    localparam int         SD = 48;
    logic                  clock = 1'b0;
    logic                  sys_rst = 1'b1;
    mwd_pkg::mwd_sfr_req_t sfr_req;
    logic                  sfr_rd, sfr_rvalid, wd_reset, wd_flag, wd_running, test_mode;
    logic [7:0]            sfr_raddr, sfr_rdata;
    int                    err_count = 0;
    int                    compares = 0;
    int                    seed = 32'hF0A2EF28;
    int                    mreg [int];
    always #12.5 clock = ~clock;
    mcu_watchdog_timer #(.FAST_DIV(FD), .SLOW_DIV(SD)) u_mcu_watchdog_timer (.clock(clock),
        .sys_rst(sys_rst), .sfr_req(sfr_req), .sfr_rd(sfr_rd), .sfr_raddr(sfr_raddr),
        .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .wd_reset(wd_reset),
        .wd_flag(wd_flag), .wd_running(wd_running), .test_mode(test_mode));
    mwd_cpu u_mwd_cpu (.clock(clock), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
        .sfr_req(sfr_req), .sfr_rd(sfr_rd), .sfr_raddr(sfr_raddr));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic hw_reset();
        @(posedge clock) sys_rst <= 1'b1;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        mreg = '{8'h86: 0, 8'h87: 8'h08, 8'hA8: 0, 8'hB8: 0};
    endtask : hw_reset
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_mwd_cpu.instr(1'b1, a, d);
        u_mwd_cpu.idle();
        mreg[a] = a == 8'h87 ? (d & 8'h40) | 8'h08 : a == 8'hB8 ? d & 8'hBF : d;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a);
        logic [7:0] d;
        logic       v;
        u_mwd_cpu.read(a, d, v);
        chk(v, 1);
        chk(d, mreg.exists(a) ? mreg[a] : 0);
    endtask : rd_chk
    task automatic start();
        u_mwd_cpu.instr(1'b1, 8'hA8, 8'(mreg[8'hA8]) | 8'h40);
        u_mwd_cpu.instr(1'b1, 8'hB8, 8'(mreg[8'hB8]) | 8'h40);
        u_mwd_cpu.idle();
    endtask : start
    // edges from refresh until the core reset shows
    task automatic time_chk(input int exp);
        int n = 0;
        while (wd_reset !== 1'b1 && n < exp + 8) begin
            @(posedge clock);
            n++;
        end
        chk(n >= exp && n <= exp + 3, 1);
    endtask : time_chk
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (40000) @(posedge clock);
        err_count++;
        final_report();
    end
    initial begin
        logic [7:0] a [4] = '{8'h86, 8'h87, 8'hA8, 8'hB8};
        hw_reset();
        foreach (a[i]) rd_chk(a[i]);
        rd_chk(8'h90);
        chk({wd_running, wd_flag}, 0);
        foreach (a[i]) wr(a[i], 8'($random(seed)) & (i == 2 ? 8'hBF : 8'hFF));
        foreach (a[i]) rd_chk(a[i]);
        chk(wd_running, 0);
        $display("test registers done");
        wr(8'h86, 8'h7F);
        u_mwd_cpu.instr(1'b1, 8'hA8, 8'h40);
        u_mwd_cpu.instr(1'b0, 8'h00, 8'h00);
        u_mwd_cpu.instr(1'b1, 8'hB8, 8'h40);
        u_mwd_cpu.idle();
        mreg[8'hA8] = 0;
        mreg[8'hB8] = 0;
        rd_chk(8'hA8);
        chk(wd_running, 0);
        $display("test split sequence done");
        wr(8'h87, 8'h40);
        @(posedge clock);
        chk(test_mode, 1);
        wr(8'h86, 8'h7E);
        start();
        time_chk(508);
        chk(wd_flag, 1);
        repeat (6) @(posedge clock);
        chk({wd_reset, wd_flag, wd_running}, 3'b011);
        $display("test quick timeout done");
        hw_reset();
        chk({wd_flag, wd_running, test_mode}, 0);
        wr(8'h86, 8'h7F);
        start();
        repeat (3000) @(posedge clock);
        start();
        time_chk(252 * FD);
        $display("test refresh done");
        hw_reset();
        wr(8'h86, 8'hFF);
        start();
        time_chk(252 * SD);
        for (int i = 1; i < 4; i++) wr(a[i], 8'h00);
        repeat (4 * SD) @(posedge clock);
        chk({wd_reset, wd_running}, 2'b01);
        $display("test slow done");
        final_report();
    end
endmodule : testbench
bind mcu_watchdog_timer mwd_chk #(.FAST_DIV(FAST_DIV), .SLOW_DIV(SLOW_DIV)) u_mwd_chk (
    .clock(clock), .sys_rst(sys_rst), .sfr_req(sfr_req), .sfr_rd(sfr_rd),
    .sfr_raddr(sfr_raddr), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
    .wd_reset(wd_reset), .wd_flag(wd_flag), .wd_running(wd_running), .test_mode(test_mode));
